/* core/iex_core.sv */
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - add with carry into working register
// - add with carry into memory byte
// - add memory to working register, flags
// - add immediate to working register, flags
// - add working register into memory byte
// - and with memory, only zero flag
// - and with immediate, only zero flag
// - and into memory, only zero flag
// - call pushes next address, loads target
// - zero fill clears byte, no flags
// - clear one bit, no flags
// - watchdog clear resets counter, sleep, expiry
// - prearm clears only after partner ran
// - lone prearm only sets its marker
// - invert byte in place, zero flag
// - invert to working register, zero flag
// - bcd fix of both nibbles and carry
// - bcd result to memory, carry only
// - decrement byte in place, zero flag
// - decrement to working register, zero flag
// - power down stops execution and clock
// - power down keeps data, clears watchdog
module iex_core #(
	parameter int MEM_DEPTH = 416,
	parameter int STACK_DEPTH = 8,
	parameter logic [15:0] WDT_PRESCALE = iex_pkg::IEX_WDT_PRESCALE
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core state
	output logic core_clk_en,
	output logic [7:0] working_register
);
	import iex_pkg::*;

	localparam int MAW = $clog2(MEM_DEPTH);
	localparam int SPW = $clog2(STACK_DEPTH);

	// ************************************************************
	// state
	// ************************************************************
	logic [7:0] mem_q [MEM_DEPTH];
	logic [7:0] work_q;
	iex_flags_t flags_q;
	logic sleep_flag;
	logic expiry_flag;
	logic pre1_q;
	logic pre2_q;
	logic halt_q;
	logic [IEX_CMD_ADDR_W-1:0] pc_q;
	logic [IEX_CMD_ADDR_W-1:0] stack_q [STACK_DEPTH];
	logic [SPW-1:0] sp_q;
	logic [15:0] wdt_pre_q;
	logic [7:0] wdt_q;
	logic [MAW-1:0] maddr_q;

	// ************************************************************
	// bus decode
	// ************************************************************
	logic wr_acc;
	logic rd_ok;
	logic exec;
	iex_op_t op;
	logic [7:0] imm;
	logic [2:0] bsel;
	logic [IEX_CMD_ADDR_W-1:0] target;
	logic [7:0] mbyte;
	logic mem_in_range;

	// single-cycle slave: never stalls
	assign pready = 1'b1;
	assign wr_acc = psel & penable & pwrite;
	assign exec = wr_acc & (paddr == IEX_OFF_CMD) & ~halt_q;
	assign op = iex_op_t'(pwdata[IEX_CMD_OP_LSB +: 8]);
	assign imm = pwdata[7:0];
	assign target = pwdata[IEX_CMD_ADDR_W-1:0];
	assign bsel = pwdata[IEX_CMD_BIT_LSB +: 3];
	assign mem_in_range = (32'(maddr_q) < MEM_DEPTH);
	assign mbyte = mem_in_range ? mem_q[maddr_q] : IEX_RST_BYTE;
	// execution clock is gated off while halted
	assign core_clk_en = ~halt_q;
	assign working_register = work_q;

	always_comb begin
		case (paddr)
			IEX_OFF_CMD, IEX_OFF_WORK, IEX_OFF_STATUS, IEX_OFF_MEM_ADDR,
			IEX_OFF_MEM_DATA, IEX_OFF_PC, IEX_OFF_WDT, IEX_OFF_SP,
			IEX_OFF_STACK_TOP: rd_ok = 1'b1;
			default: rd_ok = 1'b0;
		endcase
	end
	// unmapped addresses answer with an error
	assign pslverr = psel & penable & ~rd_ok;

	// ************************************************************
	// alu
	// ************************************************************
	logic [8:0] sum;
	logic [4:0] lsum;
	logic [7:0] addend;
	logic cin;
	logic [7:0] sres;
	logic sov;
	logic [4:0] lo_adj;
	logic [4:0] hi_adj;
	logic low_nibble_adjust_carry;
	logic bcd_c;
	logic [7:0] bcd_res;

	// operand select for the adder family
	always_comb begin
		addend = mbyte;
		cin = 1'b0;
		case (op)
			IEX_OP_ADDI: addend = imm;
			IEX_OP_ADC, IEX_OP_ADC_MEM: cin = flags_q.c;
			default: addend = mbyte;
		endcase
	end
	assign sum = {1'b0, work_q} + {1'b0, addend} + {8'h00, cin};
	assign lsum = {1'b0, work_q[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
	assign sres = sum[7:0];
	// signed overflow: equal operand signs, differing result sign
	assign sov = (work_q[7] == addend[7]) & (sres[7] != work_q[7]);

	// decimal adjust works on the working register
	always_comb begin
		if (work_q[3:0] > IEX_BCD_MAX || flags_q.half) begin
			lo_adj = {1'b0, work_q[3:0]} + {1'b0, IEX_BCD_FIX};
			low_nibble_adjust_carry = ~flags_q.half;
		end else begin
			lo_adj = {1'b0, work_q[3:0]};
			low_nibble_adjust_carry = 1'b0;
		end
		hi_adj = {1'b0, work_q[7:4]} + {4'h0, low_nibble_adjust_carry};
		if (hi_adj > {1'b0, IEX_BCD_MAX} || flags_q.c) begin
			hi_adj = hi_adj + {1'b0, IEX_BCD_FIX};
			bcd_c = 1'b1;
		end else begin
			bcd_c = flags_q.c;
		end
		bcd_res = {hi_adj[3:0], lo_adj[3:0]};
	end

	// ************************************************************
	// result and destination
	// ************************************************************
	logic [7:0] res;
	logic to_mem;
	logic to_work;
	logic upd_arith;
	logic upd_z;
	logic [7:0] bitmask;

	assign bitmask = 8'h01 << bsel;

	always_comb begin
		res = sres;
		to_mem = 1'b0;
		to_work = 1'b0;
		upd_arith = 1'b0;
		upd_z = 1'b0;
		case (op)
			IEX_OP_ADC, IEX_OP_ADD, IEX_OP_ADDI: begin
				to_work = 1'b1;
				upd_arith = 1'b1;
			end
			IEX_OP_ADC_MEM, IEX_OP_ADD_MEM: begin
				to_mem = 1'b1;
				upd_arith = 1'b1;
			end
			IEX_OP_AND: begin
				res = work_q & mbyte;
				to_work = 1'b1;
				upd_z = 1'b1;
			end
			IEX_OP_ANDI: begin
				res = work_q & imm;
				to_work = 1'b1;
				upd_z = 1'b1;
			end
			IEX_OP_AND_MEM: begin
				res = work_q & mbyte;
				to_mem = 1'b1;
				upd_z = 1'b1;
			end
			IEX_OP_ZFILL: begin
				res = IEX_RST_BYTE;
				to_mem = 1'b1;
			end
			IEX_OP_CLRB: begin
				res = mbyte & ~bitmask;
				to_mem = 1'b1;
			end
			IEX_OP_INV: begin
				res = ~mbyte;
				to_mem = 1'b1;
				upd_z = 1'b1;
			end
			IEX_OP_INVA: begin
				res = ~mbyte;
				to_work = 1'b1;
				upd_z = 1'b1;
			end
			IEX_OP_BCD: begin
				res = bcd_res;
				to_mem = 1'b1;
			end
			IEX_OP_MINUS: begin
				res = mbyte - 8'h01;
				to_mem = 1'b1;
				upd_z = 1'b1;
			end
			IEX_OP_MINUSA: begin
				res = mbyte - 8'h01;
				to_work = 1'b1;
				upd_z = 1'b1;
			end
			default: res = sres;
		endcase
	end

	// ************************************************************
	// working register
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			work_q <= IEX_RST_BYTE;
		end else if (exec && to_work) begin
			work_q <= res;
		end else if (wr_acc && paddr == IEX_OFF_WORK && !halt_q) begin
			work_q <= pwdata[7:0];
		end
	end

	// ************************************************************
	// data memory
	// ************************************************************
	// no reset on the array; contents survive power down
	always_ff @(posedge pclk) begin
		if (exec && to_mem && mem_in_range) begin
			mem_q[maddr_q] <= res;
		end else if (wr_acc && paddr == IEX_OFF_MEM_DATA && mem_in_range) begin
			mem_q[maddr_q] <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			maddr_q <= '0;
		end else if (wr_acc && paddr == IEX_OFF_MEM_ADDR) begin
			maddr_q <= pwdata[MAW-1:0];
		end
	end

	// ************************************************************
	// arithmetic flags
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q <= '0;
		end else if (exec && upd_arith) begin
			flags_q.srange <= sov;
			flags_q.z <= (sres == 8'h00);
			flags_q.half <= lsum[4];
			flags_q.c <= sum[8];
		end else if (exec && upd_z) begin
			flags_q.z <= (res == 8'h00);
		end else if (exec && op == IEX_OP_BCD) begin
			flags_q.c <= bcd_c;
		end else if (wr_acc && paddr == IEX_OFF_STATUS && !halt_q) begin
			flags_q <= iex_flags_t'(pwdata[3:0]);
		end
	end

	// ************************************************************
	// program counter and return stack
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_q <= '0;
			sp_q <= '0;
		end else if (exec && op == IEX_OP_CALL) begin
			stack_q[sp_q] <= pc_q + 1'b1;
			sp_q <= sp_q + 1'b1;
			pc_q <= target;
		end else if (exec) begin
			pc_q <= pc_q + 1'b1;
		end
	end

	// ************************************************************
	// watchdog, sleep and expiry
	// ************************************************************
	logic wdt_clr;
	logic pre_done;
	logic wdt_out;

	// a prearm clears only once its partner has been seen
	assign pre_done = (op == IEX_OP_WDC1 && pre2_q) ||
		(op == IEX_OP_WDC2 && pre1_q);
	assign wdt_clr = exec && (op == IEX_OP_WDC || op == IEX_OP_HALT ||
		((op == IEX_OP_WDC1 || op == IEX_OP_WDC2) && pre_done));
	assign wdt_out = ~halt_q & (wdt_q == 8'hFF) &
		(wdt_pre_q == WDT_PRESCALE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre1_q <= 1'b0;
			pre2_q <= 1'b0;
		end else if (wdt_clr) begin
			pre1_q <= 1'b0;
			pre2_q <= 1'b0;
		end else if (exec && op == IEX_OP_WDC1) begin
			pre1_q <= 1'b1;
		end else if (exec && op == IEX_OP_WDC2) begin
			pre2_q <= 1'b1;
		end
	end

	// counter stops with the clock during power down
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_pre_q <= '0;
			wdt_q <= '0;
		end else if (wdt_clr) begin
			wdt_pre_q <= '0;
			wdt_q <= '0;
		end else if (!halt_q) begin
			if (wdt_pre_q == WDT_PRESCALE) begin
				wdt_pre_q <= '0;
				wdt_q <= wdt_q + 8'h01;
			end else begin
				wdt_pre_q <= wdt_pre_q + 16'h0001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_flag <= 1'b0;
			expiry_flag <= 1'b0;
			halt_q <= 1'b0;
		end else begin
			if (exec && op == IEX_OP_HALT) begin
				sleep_flag <= 1'b1;
				halt_q <= 1'b1;
			end else if (wdt_clr) begin
				sleep_flag <= 1'b0;
			end
			// a time-out on the same edge as a clear still wins
			if (wdt_out) begin
				expiry_flag <= 1'b1;
			end else if (wdt_clr) begin
				expiry_flag <= 1'b0;
			end
		end
	end

	// ************************************************************
	// read data
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				IEX_OFF_WORK: prdata <= {24'h0, work_q};
				IEX_OFF_STATUS: prdata <= {23'h0, halt_q, pre2_q, pre1_q,
					expiry_flag, sleep_flag, flags_q};
				IEX_OFF_MEM_ADDR: prdata <= 32'(maddr_q);
				IEX_OFF_MEM_DATA: prdata <= {24'h0, mbyte};
				IEX_OFF_PC: prdata <= 32'(pc_q);
				IEX_OFF_WDT: prdata <= {8'h0, wdt_q, wdt_pre_q};
				IEX_OFF_SP: prdata <= 32'(sp_q);
				IEX_OFF_STACK_TOP: prdata <= 32'(stack_q[sp_q - 1'b1]);
				default: prdata <= '0;
			endcase
		end
	end
endmodule

/* core/iex_pkg.sv */
package iex_pkg;
	// ************************************************************
	// register map (word offsets as byte addresses)
	// ************************************************************
	localparam logic [7:0] IEX_OFF_CMD = 8'h00;
	localparam logic [7:0] IEX_OFF_WORK = 8'h04;
	localparam logic [7:0] IEX_OFF_STATUS = 8'h08;
	localparam logic [7:0] IEX_OFF_MEM_ADDR = 8'h0C;
	localparam logic [7:0] IEX_OFF_MEM_DATA = 8'h10;
	localparam logic [7:0] IEX_OFF_PC = 8'h14;
	localparam logic [7:0] IEX_OFF_WDT = 8'h18;
	localparam logic [7:0] IEX_OFF_SP = 8'h1C;
	localparam logic [7:0] IEX_OFF_STACK_TOP = 8'h20;

	// ************************************************************
	// status field positions
	// ************************************************************
	localparam int IEX_ST_C = 0;
	localparam int IEX_ST_HALF = 1;
	localparam int IEX_ST_Z = 2;
	localparam int IEX_ST_SRANGE = 3;
	localparam int IEX_ST_SLEEP = 4;
	localparam int IEX_ST_EXPIRY = 5;
	localparam int IEX_ST_PRE1 = 6;
	localparam int IEX_ST_PRE2 = 7;
	localparam int IEX_ST_HALT = 8;

	// ************************************************************
	// command word fields
	// ************************************************************
	localparam int IEX_CMD_OP_LSB = 16;
	localparam int IEX_CMD_BIT_LSB = 24;
	localparam int IEX_CMD_ADDR_W = 13;

	// ************************************************************
	// reset values and constants
	// ************************************************************
	localparam logic [7:0] IEX_RST_BYTE = 8'h00;
	localparam logic [3:0] IEX_BCD_MAX = 4'h9;
	localparam logic [3:0] IEX_BCD_FIX = 4'h6;
	localparam logic [15:0] IEX_WDT_PRESCALE = 16'h00FF;

	typedef enum {
		IEX_OP_NOP,
		IEX_OP_ADC,
		IEX_OP_ADC_MEM,
		IEX_OP_ADD,
		IEX_OP_ADDI,
		IEX_OP_ADD_MEM,
		IEX_OP_AND,
		IEX_OP_ANDI,
		IEX_OP_AND_MEM,
		IEX_OP_CALL,
		IEX_OP_ZFILL,
		IEX_OP_CLRB,
		IEX_OP_WDC,
		IEX_OP_WDC1,
		IEX_OP_WDC2,
		IEX_OP_INV,
		IEX_OP_INVA,
		IEX_OP_BCD,
		IEX_OP_MINUS,
		IEX_OP_MINUSA,
		IEX_OP_HALT
	} iex_op_t;

	// flag group carried together
	typedef struct packed {
		logic srange;
		logic z;
		logic half;
		logic c;
	} iex_flags_t;
endpackage

/* tb/iex_core_props.sv */
`timescale 1ns/1ps
// ****************************************
// port checker for the execute core
// ****************************************
module iex_core_props
	import iex_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// core state
	input wire logic core_clk_en,
	input wire logic [7:0] working_register
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic [7:0] opc;
	logic mem_op;
	logic z_op;
	// opcode field of a command write
	assign opc = pwdata[23:16];
	// results that land in the data byte only
	assign mem_op = opc inside {8'(IEX_OP_ADC_MEM), 8'(IEX_OP_ADD_MEM),
		8'(IEX_OP_AND_MEM), 8'(IEX_OP_ZFILL), 8'(IEX_OP_CLRB),
		8'(IEX_OP_INV), 8'(IEX_OP_BCD), 8'(IEX_OP_MINUS)};
	// results in the working register that also set zero
	assign z_op = opc inside {8'(IEX_OP_ADC), 8'(IEX_OP_ADD),
		8'(IEX_OP_ADDI), 8'(IEX_OP_AND), 8'(IEX_OP_ANDI),
		8'(IEX_OP_INVA), 8'(IEX_OP_MINUSA)};
	// command taken; a halted core ignores it
	sequence s_cmd(ok);
		psel && penable && pwrite && paddr == IEX_OFF_CMD
			&& core_clk_en && ok;
	endsequence
	// status read set up after one idle cycle
	sequence s_rd_st;
		!psel ##1 psel && !penable && !pwrite
			&& paddr == IEX_OFF_STATUS;
	endsequence
	a_halt_stops_clk: assert property (
		s_cmd(opc == 8'(IEX_OP_HALT)) |=> !core_clk_en)
		else $error("halt left the clock running");
	a_halt_stays: assert property (
		!core_clk_en |=> !core_clk_en)
		else $error("clock restarted without reset");
	a_halt_keeps_work: assert property (
		!core_clk_en |=> $stable(working_register))
		else $error("working register moved while halted");
	a_addi_sum: assert property (
		s_cmd(opc == 8'(IEX_OP_ADDI)) |=> working_register ==
			$past(working_register) + $past(pwdata[7:0]))
		else $error("immediate add wrong");
	a_andi_mask: assert property (
		s_cmd(opc == 8'(IEX_OP_ANDI)) |=> working_register ==
			($past(working_register) & $past(pwdata[7:0])))
		else $error("immediate and wrong");
	a_mem_op_keep: assert property (
		s_cmd(mem_op) |=> $stable(working_register))
		else $error("memory op touched working register");
	a_zero_flag: assert property (
		s_cmd(z_op) ##1 s_rd_st |=>
			prdata[IEX_ST_Z] == (working_register == 8'h00))
		else $error("zero flag disagrees with result");
	a_zero_wait: assert property (
		psel && penable |-> pready)
		else $error("wait state inserted");
	a_unmapped_err: assert property (
		psel && penable && paddr > IEX_OFF_STACK_TOP |-> pslverr)
		else $error("unmapped access not refused");
endmodule

bind iex_core iex_core_props u_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .core_clk_en(core_clk_en),
	.working_register(working_register)
);

/* tb/tb_top.sv */
`timescale 1ns/1ps
// ****************************************
// execute core testbench
// ****************************************
module tb_top;
	import iex_pkg::*;
	typedef struct {
		iex_op_t op;
		logic [7:0] x, a, m;
		logic [3:0] f;
		logic [7:0] ea, em;
		logic [3:0] ef;
	} iex_row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic core_clk_en;
	logic [7:0] paddr, working_register;
	logic [31:0] pwdata, prdata, rd;
	logic er;
	int n_mismatch = 0;
	int comparisons = 0;
	// op, operand, work, byte, flags in; work, byte, flags out
	iex_row_t rows[16] = '{
		'{IEX_OP_ADC,8'h00,8'h3A,8'h48,4'h1,8'h83,8'h48,4'hA},
		'{IEX_OP_ADC_MEM,8'h00,8'hFF,8'h00,4'h1,8'hFF,8'h00,4'h7},
		'{IEX_OP_ADD,8'h00,8'h80,8'h80,4'h1,8'h00,8'h80,4'hD},
		'{IEX_OP_ADDI,8'h0F,8'h01,8'h55,4'h0,8'h10,8'h55,4'h2},
		'{IEX_OP_ADD_MEM,8'h00,8'h7F,8'h01,4'h0,8'h7F,8'h80,4'hA},
		'{IEX_OP_AND,8'h00,8'hF0,8'h0F,4'hB,8'h00,8'h0F,4'hF},
		'{IEX_OP_ANDI,8'h3C,8'hF5,8'hAA,4'hF,8'h34,8'hAA,4'hB},
		'{IEX_OP_AND_MEM,8'h00,8'h0F,8'h33,4'h4,8'h0F,8'h03,4'h0},
		'{IEX_OP_ZFILL,8'h00,8'h11,8'hA5,4'hA,8'h11,8'h00,4'hA},
		'{IEX_OP_CLRB,8'h05,8'h11,8'hFF,4'h5,8'h11,8'hDF,4'h5},
		'{IEX_OP_INV,8'h00,8'h22,8'hFF,4'h0,8'h22,8'h00,4'h4},
		'{IEX_OP_INVA,8'h00,8'h22,8'h5A,4'hF,8'hA5,8'h5A,4'hB},
		'{IEX_OP_BCD,8'h00,8'h9B,8'h00,4'h0,8'h9B,8'h01,4'h1},
		'{IEX_OP_BCD,8'h00,8'h12,8'h00,4'h2,8'h12,8'h18,4'h2},
		'{IEX_OP_MINUS,8'h00,8'h33,8'h01,4'h0,8'h33,8'h00,4'h4},
		'{IEX_OP_MINUSA,8'h00,8'h33,8'h00,4'hF,8'hFF,8'h00,4'hB}};

	iex_core #(.WDT_PRESCALE(16'h0003)) u_iex_core (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .core_clk_en(core_clk_en),
		.working_register(working_register));

	// 20 MHz clock
	initial pclk = 1'b0;
	always #25 pclk = ~pclk;

	// one apb transfer; the leading edge keeps an idle cycle between
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_of_test;
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// cut a hang short; whole run needs about 2100 cycles
	initial begin
		repeat (8000) @(posedge pclk);
		n_mismatch++;
		end_of_test();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		chk({pready, pslverr, core_clk_en, working_register}, 11'h500);
		apb(1'b1, IEX_OFF_MEM_ADDR, 32'h40);
		foreach (rows[i]) begin
			apb(1'b1, IEX_OFF_WORK, {24'h0, rows[i].a});
			apb(1'b1, IEX_OFF_STATUS, {28'h0, rows[i].f});
			apb(1'b1, IEX_OFF_MEM_DATA, {24'h0, rows[i].m});
			apb(1'b1, IEX_OFF_CMD, {5'h0, rows[i].x[2:0],
				8'(rows[i].op), 8'h0, rows[i].x});
			apb(1'b0, IEX_OFF_STATUS, 32'h0);
			chk(rd[3:0], rows[i].ef);
			apb(1'b0, IEX_OFF_WORK, 32'h0);
			chk(rd, rows[i].ea);
			apb(1'b0, IEX_OFF_MEM_DATA, 32'h0);
			chk(rd, rows[i].em);
		end
		// call: next address stacked, target loaded, flags kept
		apb(1'b0, IEX_OFF_PC, 32'h0);
		chk(rd, 32'h10);
		apb(1'b1, IEX_OFF_CMD, {8'h0, 8'(IEX_OP_CALL), 16'h0ABC});
		apb(1'b0, IEX_OFF_PC, 32'h0);
		chk(rd, 32'h0ABC);
		apb(1'b0, IEX_OFF_STACK_TOP, 32'h0);
		chk(rd, 32'h11);
		apb(1'b0, IEX_OFF_STATUS, 32'h0);
		chk(rd[3:0], 4'hB);
		apb(1'b0, 8'h24, 32'h0);
		chk(er, 1'b1);
		// let the watchdog expire, then the two-step clear
		rd = 32'h0;
		while (rd[IEX_ST_EXPIRY] !== 1'b1) apb(1'b0, IEX_OFF_STATUS, 32'h0);
		apb(1'b1, IEX_OFF_CMD, {8'h0, 8'(IEX_OP_WDC1), 16'h0});
		apb(1'b0, IEX_OFF_STATUS, 32'h0);
		chk(rd[7:4], 4'h6);
		apb(1'b1, IEX_OFF_CMD, {8'h0, 8'(IEX_OP_WDC2), 16'h0});
		apb(1'b0, IEX_OFF_WDT, 32'h0);
		chk(rd[23:16], 8'h00);
		apb(1'b0, IEX_OFF_STATUS, 32'h0);
		chk(rd[7:4], 4'h0);
		// expire again, single clear
		while (rd[IEX_ST_EXPIRY] !== 1'b1) apb(1'b0, IEX_OFF_STATUS, 32'h0);
		apb(1'b1, IEX_OFF_CMD, {8'h0, 8'(IEX_OP_WDC), 16'h0});
		apb(1'b0, IEX_OFF_WDT, 32'h0);
		chk(rd[23:16], 8'h00);
		apb(1'b0, IEX_OFF_STATUS, 32'h0);
		chk(rd[5:4], 2'h0);
		// power down; later commands must be ignored
		apb(1'b1, IEX_OFF_WORK, 32'h5C);
		apb(1'b1, IEX_OFF_MEM_DATA, 32'h6B);
		apb(1'b1, IEX_OFF_CMD, {8'h0, 8'(IEX_OP_HALT), 16'h0});
		apb(1'b0, IEX_OFF_WDT, 32'h0);
		chk(rd[23:0], 24'h0);
		apb(1'b0, IEX_OFF_STATUS, 32'h0);
		chk(rd[8:4], 5'h11);
		apb(1'b1, IEX_OFF_CMD, {8'h0, 8'(IEX_OP_ADDI), 16'h01});
		apb(1'b1, IEX_OFF_WORK, 32'h77);
		apb(1'b0, IEX_OFF_WORK, 32'h0);
		chk(rd, 32'h5C);
		chk({core_clk_en, working_register}, 9'h05C);
		apb(1'b0, IEX_OFF_MEM_DATA, 32'h0);
		chk(rd, 32'h6B);
		// mid-run reset is the only way out of halt
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({core_clk_en, working_register}, 9'h100);
		end_of_test();
	end
endmodule
